// File: design/serial_port_pkg.sv
// Constants, types and helpers for the serial port block
// Notes on behaviour
// - Parity none, odd, even, mark, space
// - Five to eight data bits per character
// - One or two stop bits appended
// - Reply waits minimum response delay first
// - Data held off lead time after send request
// - Send request held trail time after last byte
// - Clear-to-send ignored when gate is zero
// - Gate one: send only with clear-to-send high
// - Enquiry waits delay after link acknowledge
// - Command index limited to list length
// - Commands spaced by minimum command delay
// - Retries bypass command spacing
// - Fault records at location, none at minus one
// - Port works only when enabled
// - Role zero master, one slave
// - Bit rate entered as plain number or short code (115200 only as 115 or 1152)
package serial_port_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_TIME_NS    = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  typedef logic [13:0] reg_idx_t;
  localparam reg_idx_t IDX_ENABLE   = 14'h1392;
  localparam reg_idx_t IDX_ROLE     = 14'h1393;
  localparam reg_idx_t IDX_BAUD     = 14'h1397;
  localparam reg_idx_t IDX_PARITY   = 14'h1398;
  localparam reg_idx_t IDX_BITS     = 14'h1399;
  localparam reg_idx_t IDX_STOP     = 14'h139A;
  localparam reg_idx_t IDX_HOLDOFF  = 14'h139B;
  localparam reg_idx_t IDX_LEAD     = 14'h139C;
  localparam reg_idx_t IDX_TRAIL    = 14'h139D;
  localparam reg_idx_t IDX_CTS_GATE = 14'h139E;
  localparam reg_idx_t IDX_ENQ      = 14'h139F;
  localparam reg_idx_t IDX_CMD_LEN  = 14'h13A0;
  localparam reg_idx_t IDX_SPACING  = 14'h13A1;
  localparam reg_idx_t IDX_FAULT    = 14'h13A2;
  localparam reg_idx_t IDX_STATUS   = 14'h13B0;
  localparam reg_idx_t IDX_MASK     = 14'h13B1;
  localparam reg_idx_t IDX_CONTROL  = 14'h13B2;
  localparam reg_idx_t IDX_TX_DATA  = 14'h13B3;
  localparam reg_idx_t IDX_RX_DATA  = 14'h13B4;
  localparam reg_idx_t IDX_CODE     = 14'h13B5;
  localparam reg_idx_t IDX_STATE    = 14'h13B6;
  localparam logic [15:0] BAUD_RESET  = 16'h2580;
  localparam logic [15:0] BITS_RESET  = 16'h0008;
  localparam logic [15:0] STOP_RESET  = 16'h0001;
  localparam logic [15:0] STOP_TWO    = 16'h0002;
  localparam logic [15:0] CMD_MAX     = 16'h0064;
  localparam logic [15:0] LOC_NONE    = 16'hFFFF;
  localparam logic [15:0] LOC_MAX     = 16'h1387;
  localparam logic [2:0]  PAR_NONE    = 3'h0;
  localparam logic [2:0]  PAR_ODD     = 3'h1;
  localparam logic [2:0]  PAR_EVEN    = 3'h2;
  localparam logic [2:0]  PAR_MARK    = 3'h3;
  localparam logic [2:0]  PAR_SPACE   = 3'h4;
  localparam logic [7:0]  DLE_CODE    = 8'h10;
  localparam logic [7:0]  ACK_CODE    = 8'h06;
  localparam int unsigned CTL_START   = 0;
  localparam int unsigned CTL_END     = 3;
  localparam int unsigned EV_TX_DONE  = 0;
  localparam int unsigned EV_RX_BYTE  = 1;
  localparam int unsigned EV_ACK      = 2;
  localparam int unsigned EV_REFUSED  = 3;
  localparam int unsigned EV_RX_ERR   = 4;
  localparam int unsigned EV_W        = 5;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_HOLD  = 5'h02,
    TX_LEAD  = 5'h04,
    TX_SEND  = 5'h08,
    TX_TRAIL = 5'h10
  } tx_state_t;
  typedef enum logic [1:0] {
    MSG_CMD = 2'h0, MSG_RETRY = 2'h1, MSG_REPLY = 2'h2, MSG_ENQ = 2'h3
  } msg_kind_t;
  typedef struct packed {
    logic [2:0] parity;
    logic [3:0] bits;
    logic       two_stop;
  } frame_cfg_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } fault_rec_t;

  function automatic int unsigned char_len(input logic [3:0] b);
    return (b >= 4'h5 && b <= 4'h8) ? int'(b) : 8;
  endfunction

  function automatic logic par_on(input logic [2:0] p);
    return p >= PAR_ODD && p <= PAR_SPACE;
  endfunction

  function automatic logic par_bit(input logic [7:0] d,
                                   input frame_cfg_t c);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 8; i++) if (i < char_len(c.bits)) x ^= d[i];
    case (c.parity)
      PAR_ODD:  return ~x;
      PAR_MARK: return 1'b1;
      PAR_EVEN: return x;
      default:  return 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] frame_len(input frame_cfg_t c);
    return 4'(1 + char_len(c.bits) + (par_on(c.parity) ? 1 : 0) +
              (c.two_stop ? 2 : 1));
  endfunction

  function automatic logic [16:0] ms_load(input logic [15:0] v);
    // One extra tick so the wait is never short
    return (v == 16'h0000) ? 17'h00000 : {1'b0, v} + 17'h00001;
  endfunction

  function automatic logic [19:0] baud_divisor(input logic [15:0] r);
    int unsigned bps;
    case (int'(r))
      110, 150, 300, 600: bps = int'(r);
      12, 1200:           bps = 1200;
      24, 2400:           bps = 2400;
      48, 4800:           bps = 4800;
      14, 114, 14400:     bps = 14400;
      19, 192, 19200:     bps = 19200;
      28, 288, 28800:     bps = 28800;
      38, 384, 38400:     bps = 38400;
      57, 576, 57600:     bps = 57600;
      115, 1152:          bps = 115200;
      default:            bps = 9600;
    endcase
    return 20'(CLK_HZ / bps);
  endfunction
endpackage

// File: design/serial_port_line_and_modem_control.sv
// Serial port framing, modem control and command pacing
`timescale 1ns/1ns
`default_nettype none
module serial_port_line_and_modem_control
  import serial_port_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial line and modem
  input  wire logic        rx_in,
  input  wire logic        cts_in,
  output logic             tx_out,
  output logic             rts_out,
  // Fault record write to data table
  output fault_rec_t       fault_rec,
  // Interrupt
  output logic             irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic [15:0] enable_q, role_q, baud_q, parity_q, bits_q, stop_q;
  logic [15:0] holdoff_q, lead_q, trail_q, gate_q, enq_q, cmd_len_q;
  logic [15:0] spacing_q, loc_q, cmd_idx_q;
  logic [EV_W-1:0] status_q, mask_q, ev;
  logic [7:0]  tx_data_q, rx_data_q, prev_byte_q;
  logic        tx_full_q, end_q, irq_q, rts_q, tx_q;
  logic        wr_q, rd_now, acc, cts_m, cts_s, rx_m, rx_s, rx_p;
  reg_idx_t    wr_idx_q, rd_idx;
  logic [31:0] hrdata_q, ms_cnt_q;
  logic [15:0] wdat, rd_val;
  logic        ms_tick;
  logic [16:0] hold_ms_q, space_ms_q, enq_ms_q;
  tx_state_t   st_q;
  msg_kind_t   kind_q, start_kind;
  logic        start_req, start_ok, hold_go, tx_idle, tx_load, can_load;
  logic [11:0] tx_sh_q, rx_sh_q;
  logic [3:0]  tx_left_q, rx_cnt_q, rx_par_idx;
  logic [19:0] tx_div_q, rx_div_q, div;
  logic        rx_busy_q, rx_done, rx_bad;
  logic [7:0]  rx_byte;
  frame_cfg_t  cfg;
  fault_rec_t  fault_q;

  assign cfg  = '{parity: parity_q[2:0], bits: bits_q[3:0],
                  two_stop: (stop_q == STOP_TWO)};
  assign div  = baud_divisor(baud_q);
  assign wdat = hwdata[15:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign tx_out    = tx_q;
  assign rts_out   = rts_q;
  assign irq       = irq_q;
  assign fault_rec = fault_q;

  // Pin synchronisers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {cts_m, cts_s, rx_m, rx_s, rx_p} <= 5'h07;
      {cts_m, cts_s} <= 2'h0;
    end else begin
      cts_m <= cts_in;
      cts_s <= cts_m;
      rx_m  <= rx_in;
      rx_s  <= rx_m;
      rx_p  <= rx_s;
    end
  end

  // Bus address phase; read data registered for the data phase
  assign acc    = hsel && htrans[1] && hready;
  assign rd_now = acc && !hwrite;
  assign rd_idx = haddr[15:2];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_q     <= 1'b0;
      wr_idx_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= acc && hwrite && haddr[31:16] == 16'h0000;
      if (acc) wr_idx_q <= rd_idx;
      if (rd_now) hrdata_q <= {16'h0000, rd_val};
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    if (haddr[31:16] != 16'h0000) rd_val = 16'h0000;
    else if (rd_idx == IDX_ENABLE)   rd_val = enable_q;
    else if (rd_idx == IDX_ROLE)     rd_val = role_q;
    else if (rd_idx == IDX_BAUD)     rd_val = baud_q;
    else if (rd_idx == IDX_PARITY)   rd_val = parity_q;
    else if (rd_idx == IDX_BITS)     rd_val = bits_q;
    else if (rd_idx == IDX_STOP)     rd_val = stop_q;
    else if (rd_idx == IDX_HOLDOFF)  rd_val = holdoff_q;
    else if (rd_idx == IDX_LEAD)     rd_val = lead_q;
    else if (rd_idx == IDX_TRAIL)    rd_val = trail_q;
    else if (rd_idx == IDX_CTS_GATE) rd_val = gate_q;
    else if (rd_idx == IDX_ENQ)      rd_val = enq_q;
    else if (rd_idx == IDX_CMD_LEN)  rd_val = cmd_len_q;
    else if (rd_idx == IDX_SPACING)  rd_val = spacing_q;
    else if (rd_idx == IDX_FAULT)    rd_val = loc_q;
    else if (rd_idx == IDX_STATUS)   rd_val = 16'(status_q);
    else if (rd_idx == IDX_MASK)     rd_val = 16'(mask_q);
    else if (rd_idx == IDX_RX_DATA)  rd_val = {8'h00, rx_data_q};
    else if (rd_idx == IDX_TX_DATA)  rd_val = {8'h00, tx_data_q};
    else if (rd_idx == IDX_STATE)
      rd_val = {cmd_idx_q[7:0], tx_full_q, cts_s, rts_q, 5'(st_q)};
  end

  // Configuration registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {enable_q, role_q, parity_q, holdoff_q, lead_q} <= '0;
      {trail_q, gate_q, enq_q, cmd_len_q, spacing_q} <= '0;
      mask_q   <= '0;
      baud_q   <= BAUD_RESET;
      bits_q   <= BITS_RESET;
      stop_q   <= STOP_RESET;
      loc_q    <= LOC_NONE;
    end else if (wr_q) begin
      if (wr_idx_q == IDX_ENABLE)        enable_q  <= wdat;
      else if (wr_idx_q == IDX_ROLE)     role_q    <= wdat;
      else if (wr_idx_q == IDX_BAUD)     baud_q    <= wdat;
      else if (wr_idx_q == IDX_PARITY)   parity_q  <= wdat;
      else if (wr_idx_q == IDX_BITS)     bits_q    <= wdat;
      else if (wr_idx_q == IDX_STOP)     stop_q    <= wdat;
      else if (wr_idx_q == IDX_HOLDOFF)  holdoff_q <= wdat;
      else if (wr_idx_q == IDX_LEAD)     lead_q    <= wdat;
      else if (wr_idx_q == IDX_TRAIL)    trail_q   <= wdat;
      else if (wr_idx_q == IDX_CTS_GATE) gate_q    <= wdat;
      else if (wr_idx_q == IDX_ENQ)      enq_q     <= wdat;
      else if (wr_idx_q == IDX_CMD_LEN)
        cmd_len_q <= (wdat > CMD_MAX) ? CMD_MAX : wdat;
      else if (wr_idx_q == IDX_SPACING)  spacing_q <= wdat;
      else if (wr_idx_q == IDX_FAULT)    loc_q     <= wdat;
      else if (wr_idx_q == IDX_MASK)     mask_q    <= wdat[EV_W-1:0];
    end
  end

  // Sticky status, cleared by reading it; a new event wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= (rd_now && rd_idx == IDX_STATUS) ? ev : (status_q | ev);
      irq_q    <= |(status_q & mask_q);
    end
  end

  // Fault record, suppressed at the no-location value
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault_q <= '0;
    end else begin
      fault_q.valid <= wr_q && wr_idx_q == IDX_CODE &&
                       loc_q <= LOC_MAX;
      if (wr_q && wr_idx_q == IDX_CODE) begin
        fault_q.addr <= loc_q;
        fault_q.data <= wdat;
      end
    end
  end

  // Millisecond tick
  assign ms_tick = (ms_cnt_q == MS_TICK_CYCLES - 1);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) ms_cnt_q <= 32'h0000_0000;
    else ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
  end

  // Message start requests
  assign start_kind = msg_kind_t'(wdat[2:1]);
  assign start_req  = wr_q && wr_idx_q == IDX_CONTROL && wdat[CTL_START];
  assign start_ok   = start_req && st_q == TX_IDLE && enable_q == 16'h0001 &&
                      ((start_kind == MSG_REPLY) == role_q[0]) &&
                      (start_kind != MSG_CMD || cmd_len_q != 16'h0000);
  assign hold_go = hold_ms_q == 17'h00000 &&
                   !(kind_q == MSG_CMD && space_ms_q != 17'h00000) &&
                   !(kind_q == MSG_ENQ && enq_ms_q != 17'h00000);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_idx_q <= '0;
    end else if (cmd_idx_q >= cmd_len_q && cmd_idx_q != 16'h0000) begin
      cmd_idx_q <= '0;
    end else if (start_ok && start_kind == MSG_CMD) begin
      cmd_idx_q <= (cmd_idx_q + 16'h0001 >= cmd_len_q) ? 16'h0000
                 : cmd_idx_q + 16'h0001;
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q      <= TX_IDLE;
      kind_q    <= MSG_CMD;
      hold_ms_q <= '0;
      rts_q     <= 1'b0;
    end else if (enable_q != 16'h0001) begin
      st_q      <= TX_IDLE;
      hold_ms_q <= '0;
      rts_q     <= 1'b0;
    end else begin
      if (ms_tick && hold_ms_q != 17'h00000)
        hold_ms_q <= hold_ms_q - 17'h00001;
      case (st_q)
        TX_IDLE: if (start_ok) begin
          st_q      <= TX_HOLD;
          kind_q    <= start_kind;
          hold_ms_q <= (start_kind == MSG_REPLY) ? ms_load(holdoff_q)
                       : 17'h00000;
        end
        TX_HOLD: if (hold_go) begin
          st_q      <= TX_LEAD;
          rts_q     <= 1'b1;
          hold_ms_q <= ms_load(lead_q);
        end
        TX_LEAD: if (hold_ms_q == 17'h00000) st_q <= TX_SEND;
        TX_SEND: if (end_q && !tx_full_q && tx_idle) begin
          st_q      <= TX_TRAIL;
          hold_ms_q <= ms_load(trail_q);
        end
        TX_TRAIL: if (hold_ms_q == 17'h00000) begin
          st_q  <= TX_IDLE;
          rts_q <= 1'b0;
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end

  // Command spacing and enquiry delay timers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) space_ms_q <= '0;
    else if (st_q == TX_HOLD && hold_go && kind_q == MSG_CMD)
      space_ms_q <= ms_load(spacing_q);
    else if (ms_tick && space_ms_q != 17'h00000)
      space_ms_q <= space_ms_q - 17'h00001;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) enq_ms_q <= '0;
    else if (ev[EV_ACK]) enq_ms_q <= ms_load(enq_q);
    else if (ms_tick && enq_ms_q != 17'h00000)
      enq_ms_q <= enq_ms_q - 17'h00001;
  end

  // Character shifter
  assign tx_idle  = tx_left_q == 4'h0 && tx_div_q == 20'h00000;
  assign can_load = st_q == TX_SEND && tx_idle && tx_full_q;
  assign tx_load  = can_load && (gate_q != 16'h0001 || cts_s);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_sh_q   <= '1;
      tx_left_q <= '0;
      tx_div_q  <= '0;
      tx_q      <= 1'b1;
      tx_full_q <= 1'b0;
      tx_data_q <= '0;
      end_q     <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_sh_q   <= '1;
        for (int i = 0; i < 8; i++)
          if (i < char_len(cfg.bits)) tx_sh_q[1+i] <= tx_data_q[i];
        tx_sh_q[0] <= 1'b0;
        if (par_on(cfg.parity))
          tx_sh_q[4'(1 + char_len(cfg.bits))] <= par_bit(tx_data_q, cfg);
        tx_left_q <= frame_len(cfg);
        tx_full_q <= 1'b0;
      end else if (tx_left_q != 4'h0 && tx_div_q == 20'h00000) begin
        tx_q      <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_div_q  <= div - 20'h00001;
      end else if (tx_div_q != 20'h00000) begin
        tx_div_q <= tx_div_q - 20'h00001;
      end
      if (st_q == TX_IDLE && enable_q != 16'h0001) tx_full_q <= 1'b0;
      if (wr_q && wr_idx_q == IDX_TX_DATA) begin
        tx_data_q <= wdat[7:0];
        tx_full_q <= 1'b1;
      end
      if (st_q == TX_TRAIL || enable_q != 16'h0001) end_q <= 1'b0;
      if (wr_q && wr_idx_q == IDX_CONTROL && wdat[CTL_END]) end_q <= 1'b1;
    end
  end

  // Receiver, sampled at mid-bit
  assign rx_par_idx = 4'(1 + char_len(cfg.bits));
  assign rx_byte = rx_sh_q[8:1] & (8'hFF >> (8 - char_len(cfg.bits)));
  assign rx_done = rx_busy_q && rx_div_q == 20'h00000 &&
                   rx_cnt_q == frame_len(cfg) - (cfg.two_stop ? 4'h2 : 4'h1);
  assign rx_bad  = !rx_s || (par_on(cfg.parity) &&
                   rx_sh_q[rx_par_idx] != par_bit(rx_byte, cfg));
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_busy_q   <= 1'b0;
      rx_cnt_q    <= '0;
      rx_div_q    <= '0;
      rx_sh_q     <= '0;
      rx_data_q   <= '0;
      prev_byte_q <= '0;
    end else if (!rx_busy_q) begin
      if (enable_q == 16'h0001 && rx_p && !rx_s) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 4'h0;
        rx_div_q  <= div >> 1;
      end
    end else if (rx_div_q != 20'h00000) begin
      rx_div_q <= rx_div_q - 20'h00001;
    end else begin
      rx_sh_q[rx_cnt_q] <= rx_s;
      rx_cnt_q <= rx_cnt_q + 4'h1;
      rx_div_q <= div - 20'h00001;
      if ((rx_cnt_q == 4'h0 && rx_s) || rx_done) rx_busy_q <= 1'b0;
      if (rx_done && !rx_bad) begin
        rx_data_q   <= rx_byte;
        prev_byte_q <= rx_byte;
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_TX_DONE] = st_q == TX_TRAIL && hold_ms_q == 17'h00000 &&
                     enable_q == 16'h0001;
    ev[EV_RX_BYTE] = rx_done && !rx_bad;
    ev[EV_RX_ERR]  = rx_done && rx_bad;
    ev[EV_ACK]     = ev[EV_RX_BYTE] && !role_q[0] &&
                     prev_byte_q == DLE_CODE && rx_byte == ACK_CODE;
    ev[EV_REFUSED] = start_req && !start_ok;
  end

  reply_wait_a: assert property (st_q == TX_HOLD && kind_q == MSG_REPLY &&
    hold_ms_q != 17'h00000 |=> st_q != TX_LEAD)
    else $error("reply left hold before its delay");
  lead_idle_a: assert property (st_q == TX_LEAD |-> rts_q && tx_q)
    else $error("line not idle with send request during lead");
  trail_rts_a: assert property ($fell(rts_q) |->
    $past(st_q) == TX_TRAIL || enable_q != 16'h0001)
    else $error("send request dropped outside trail");
  cts_ignore_a: assert property (can_load && gate_q != 16'h0001
    |=> tx_left_q == frame_len(cfg))
    else $error("character held with gate off");
  cts_gate_a: assert property (gate_q == 16'h0001 && !cts_s && tx_idle
    |=> tx_left_q == 4'h0)
    else $error("character started without clear-to-send");
  enq_wait_a: assert property (st_q == TX_HOLD && kind_q == MSG_ENQ &&
    enq_ms_q != 17'h00000 |=> st_q == TX_HOLD)
    else $error("enquiry sent before its delay");
  cmd_index_a: assert property (cmd_len_q != 16'h0000 &&
    !(wr_q && wr_idx_q == IDX_CMD_LEN)
    |=> cmd_idx_q < cmd_len_q || $past(cmd_idx_q) >= $past(cmd_len_q))
    else $error("command index past list length");
  cmd_space_a: assert property (st_q == TX_HOLD && kind_q == MSG_CMD &&
    space_ms_q != 17'h00000 |=> st_q == TX_HOLD)
    else $error("command issued inside spacing");
  retry_fast_a: assert property (st_q == TX_HOLD && kind_q == MSG_RETRY &&
    enable_q == 16'h0001 |=> st_q == TX_LEAD && rts_q)
    else $error("retry was delayed");
  fault_none_a: assert property (fault_q.valid |->
    $past(loc_q) <= LOC_MAX && fault_q.addr == $past(loc_q))
    else $error("fault record with no location");
  port_off_a: assert property (enable_q != 16'h0001 |=>
    st_q == TX_IDLE && !rts_q)
    else $error("disabled port is active");
  stop_cover_c: cover property (st_q == TX_TRAIL ##1 st_q == TX_IDLE);
  ack_cover_c: cover property (ev[EV_ACK]);
  fault_cover_c: cover property (fault_q.valid);
endmodule // serial_port_line_and_modem_control
`default_nettype wire

// File: verification/serial_port_far_station.sv
// Far-end station model: modem answer and serial sender
`timescale 1ns/1ns
`default_nettype none
module serial_port_far_station #(
  parameter int LAG = 300
) (
  // Clock
  input  wire logic clk_sys,
  // Modem and line
  input  wire logic rts_out,
  output var logic  cts_in = 1'b0,
  output var logic  rx_in = 1'b1
);
  int n = 0;
  // Modem grants clear-to-send some cycles after the request
  always @(posedge clk_sys)
    if (!rts_out) begin
      n <= 0;
      cts_in <= 1'b0;
    end else if (n == LAG) cts_in <= 1'b1;
    else n <= n + 1;
  // One character, eight data bits LSB first, one stop
  task automatic send(input logic [7:0] b, input int bp);
    for (int i = 0; i < 10; i++) begin
      rx_in <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (bp) @(posedge clk_sys);
    end
  endtask
endmodule // serial_port_far_station
`default_nettype wire

// File: verification/serial_port_line_and_modem_control_test.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ns
`default_nettype none
module serial_port_line_and_modem_control_test;
  import serial_port_pkg::*;
  localparam int T = 20;
  localparam int LAG = 300;
  localparam int LEAD = 1;
  localparam int TRAIL = 2;
  localparam int BP = CLK_HZ / 115200;
  localparam int SPACE = 10, HOLDOFF = 3, ENQ = 60;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic        hreadyout, hresp, tx_out, rts_out, irq, rx_in, cts_in;
  fault_rec_t  fault_rec;
  logic [15:0] got, exp, loc, fr_a, fr_d;
  logic [7:0]  dat;
  int          err_count = 0, checks = 0, fr_n = 0, n0, nb, st, len, n;
  time         t_up, t_dn, t_tx;
  always #5 clk_sys = ~clk_sys;
  always @(posedge rts_out) t_up = $time;
  always @(negedge rts_out) t_dn = $time;
  always @(posedge clk_sys)
    if (fault_rec.valid === 1'b1) begin
      fr_n++;
      fr_a = fault_rec.addr;
      fr_d = fault_rec.data;
    end
  serial_port_line_and_modem_control #(.MS_TICK_CYCLES(T)) dut (
    .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_in,
    .cts_in, .tx_out, .rts_out, .fault_rec, .irq);
  serial_port_far_station #(.LAG(LAG)) far (
    .clk_sys, .rts_out, .cts_in, .rx_in);
  task automatic report_and_stop;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_up(input logic bad);
    if (bad) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    give_up(hreadyout !== 1'b1);
  endtask
  task automatic ahb(input logic w, input reg_idx_t i, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0000, i, 2'b00};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    rdy();
    r = hrdata;
  endtask
  task automatic rd(input reg_idx_t i, input logic [15:0] want);
    ahb(1'b0, i, 16'h0000);
    check(r, {16'h0000, want});
    check(32'(hresp), 32'h0);
  endtask
  task automatic wait_for(input logic on_rts, input logic lvl);
    for (n = 0; n < 9000 && (on_rts ? rts_out : tx_out) !== lvl; n++)
      @(posedge clk_sys);
    give_up(n >= 9000);
  endtask
  // Empty message of kind k; send request must rise lo..hi cycles later
  task automatic msg(input logic [1:0] k, input int lo, input int hi);
    time t0;
    ahb(1'b1, IDX_CONTROL, {12'h000, 1'b1, k, 1'b1});
    t0 = $time;
    wait_for(1'b1, 1'b1);
    check(32'(t_up >= t0 + lo * 10 && t_up <= t0 + hi * 10), 1);
    wait_for(1'b1, 1'b0);
  endtask
  // Expected line bits, start bit first
  function automatic logic [15:0] frame(input logic [7:0] d, input int p);
    logic x;
    x = ^(d & 8'((1 << nb) - 1));
    frame = {7'h00, d, 1'b0} & 16'((1 << (nb + 1)) - 1);
    len = nb + 1;
    if (p != 0) begin
      frame[len] = (p == 1) ? ~x : (p == 2) ? x : (p == 3);
      len++;
    end
    for (int s = 0; s < st; s++) begin
      frame[len] = 1'b1;
      len++;
    end
  endfunction
  initial begin
    void'($urandom(5883));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(IDX_BAUD, BAUD_RESET);
    rd(IDX_BITS, BITS_RESET);
    rd(IDX_STOP, STOP_RESET);
    rd(IDX_FAULT, LOC_NONE);
    rd(14'h1000, 16'h0000);
    ahb(1'b1, IDX_ENABLE, 16'h0001);
    ahb(1'b1, IDX_LEAD, 16'(LEAD));
    ahb(1'b1, IDX_TRAIL, 16'(TRAIL));
    ahb(1'b1, IDX_CMD_LEN, 16'h0003);
    for (int p = 0; p < 5; p++) begin
      nb = 5 + $urandom % 4;
      st = 1 + $urandom % 2;
      dat = 8'($urandom);
      exp = frame(dat, p);
      ahb(1'b1, IDX_BAUD, p < 3 ? 16'h0480 : 16'h0073);
      ahb(1'b1, IDX_PARITY, 16'(p));
      ahb(1'b1, IDX_BITS, 16'(nb));
      ahb(1'b1, IDX_STOP, 16'(st));
      ahb(1'b1, IDX_CTS_GATE, 16'(p % 2));
      ahb(1'b1, IDX_TX_DATA, {8'h00, dat});
      ahb(1'b1, IDX_CONTROL, 16'h0009);
      wait_for(1'b0, 1'b0);
      t_tx = $time;
      repeat (BP / 2) @(posedge clk_sys);
      for (int i = 0; i < len; i++) begin
        got[i] = tx_out;
        repeat (BP) @(posedge clk_sys);
      end
      check(got & 16'((1 << len) - 1), exp);
      check(32'(t_tx - t_up >= LEAD * T * 10), 1);
      check(32'(t_tx > t_up + LAG * 10), 32'(p % 2));
      wait_for(1'b1, 1'b0);
      check(32'(t_dn + 10 - t_tx >= (len * BP + TRAIL * T) * 10), 1);
    end
    ahb(1'b0, IDX_STATE, 16'h0000);
    check(32'(r[15:8]), 32'h2);
    ahb(1'b1, IDX_SPACING, 16'(SPACE));
    ahb(1'b1, IDX_HOLDOFF, 16'(HOLDOFF));
    msg(2'h0, 1, 1);
    t_tx = t_up;
    msg(2'h0, 2, 400);
    check(32'(t_up - t_tx >= SPACE * T * 10), 1);
    msg(2'h1, 1, 1);
    ahb(1'b1, IDX_ROLE, 16'h0001);
    msg(2'h2, HOLDOFF * T, HOLDOFF * T + T + 2);
    ahb(1'b1, IDX_ROLE, 16'h0000);
    ahb(1'b1, IDX_PARITY, 16'h0000);
    ahb(1'b1, IDX_BITS, 16'h0008);
    ahb(1'b1, IDX_STOP, 16'h0001);
    ahb(1'b1, IDX_ENQ, 16'(ENQ));
    far.send(DLE_CODE, BP);
    far.send(ACK_CODE, BP);
    msg(2'h3, ENQ * T - BP, ENQ * T);
    repeat (BP) @(posedge clk_sys);
    rd(IDX_RX_DATA, 16'(ACK_CODE));
    ahb(1'b0, IDX_STATUS, 16'h0000);
    check(32'(r[2:1]), 32'h3);
    for (int k = 0; k < 2; k++) begin
      loc = k ? LOC_NONE : 16'($urandom % 5000);
      ahb(1'b1, IDX_FAULT, loc);
      n0 = fr_n;
      ahb(1'b1, IDX_CODE, 16'h00A5);
      repeat (3) @(posedge clk_sys);
      check(32'(fr_n - n0), 32'(1 - k));
      if (k == 0) check(32'(fr_a), 32'(loc));
      if (k == 0) check(32'(fr_d), 32'h0000_00A5);
    end
    ahb(1'b1, IDX_MASK, 16'h0008);
    ahb(1'b1, IDX_ENABLE, 16'h0000);
    ahb(1'b1, IDX_CONTROL, 16'h0009);
    repeat (3) @(posedge clk_sys);
    check(32'(irq), 32'h1);
    ahb(1'b0, IDX_STATUS, 16'h0000);
    check(32'(r[3]), 32'h1);
    repeat (3) @(posedge clk_sys);
    check(32'(irq), 32'h0);
    ahb(1'b1, IDX_CMD_LEN, 16'h00C8);
    rd(IDX_CMD_LEN, CMD_MAX);
    report_and_stop();
  end
endmodule // serial_port_line_and_modem_control_test
`default_nettype wire
